// [iowd_asserts.sv]
// Checker for the I/O window decoder, watching only the top module's ports.
// Assumes accepted APB writes are shadowed here to know control and enable bits.
`timescale 1ns/100ps
module iowd_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        host_io_valid,
  input wire [15:0] host_io_addr,
  input wire        card_io_width_indicator_n,
  input wire        io_claim,
  input wire        card_cycle,
  input wire [15:0] card_io_addr,
  input wire        card_width16,
  input wire        card_timing_set1,
  input wire        card_window1
);
  reg  [7:0] ctl_reg;
  reg  [7:0] map_reg;
  wire       wr_ok = psel && penable && pready && pwrite;
  wire       go_wr = wr_ok && paddr[9:2] == 8'h40 && pwdata[16];
  // Shadows follow accepted writes, so no view of the design body is needed.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= 8'h00;
      map_reg <= 8'h00;
    end else if (wr_ok && paddr[9:2] == 8'h07) begin
      ctl_reg <= pwdata[7:0];
    end else if (wr_ok && paddr[9:2] == 8'h06) begin
      map_reg <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  claim_cycle_a: assert property (io_claim == card_cycle)
    else $error("claim and card cycle differ");
  claim_cause_a: assert property (io_claim |-> $past(host_io_valid) || $past(go_wr) || $past(go_wr, 2))
    else $error("claim without an access");
  hold_out_a: assert property (!io_claim |-> $stable(card_io_addr) && $stable(card_window1))
    else $error("card outputs moved without a hit");
  map_enable_a: assert property (io_claim |-> (card_window1 ? $past(map_reg[7]) : $past(map_reg[6])))
    else $error("claim by a disabled window");
  width_w0_a: assert property (io_claim && !card_window1 && $past(host_io_valid) |->
    card_width16 == ($past(ctl_reg[1]) ? !$past(card_io_width_indicator_n) : $past(ctl_reg[0])))
    else $error("window 0 width wrong");
  width_w1_a: assert property (io_claim && card_window1 && $past(host_io_valid) |->
    card_width16 == ($past(ctl_reg[5]) ? !$past(card_io_width_indicator_n) : $past(ctl_reg[4])))
    else $error("window 1 width wrong");
  timing_sel_a: assert property (io_claim |-> card_timing_set1 ==
    (card_window1 ? $past(ctl_reg[7]) : $past(ctl_reg[3])))
    else $error("timing set wrong");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("register answer late or long");
endmodule
bind iowd_top iowd_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .host_io_valid(host_io_valid), .host_io_addr(host_io_addr),
  .card_io_width_indicator_n(card_io_width_indicator_n), .io_claim(io_claim), .card_cycle(card_cycle),
  .card_io_addr(card_io_addr), .card_width16(card_width16), .card_timing_set1(card_timing_set1),
  .card_window1(card_window1));

// [iowd_card_model.sv]
// Card-side model: returns the card's 16-bit width indicator, active low.
// Assumes the host strobe marks the only cycle in which the indicator is valid.
`timescale 1ns/100ps
module iowd_card_model (
  input  wire pclk,
  input  wire host_io_valid,
  input  wire card_wide,
  output wire card_io_width_indicator_n
);
  reg junk_reg = 1'b0;
  // Outside an access the pin is not driven, so it toggles rather than keep a stale level.
  always @(posedge pclk) begin
    junk_reg <= ~junk_reg;
  end
  assign card_io_width_indicator_n = host_io_valid ? !card_wide : junk_reg;
endmodule

// [iowd_defs.vh]
// Constants for the I/O window decoder: register indexes, field positions, reset values.
// Assumes inclusion by iowd_top.v and the testbench, not by iowd_match.v; holds definitions only.
`ifndef IOWD_DEFS_VH
`define IOWD_DEFS_VH
// Register indexes; some are not multiples of four, so byte address is index times four.
`define IOWD_IDX_MAP_ENABLE   8'h06
`define IOWD_IDX_WIN_CTRL     8'h07
`define IOWD_IDX_W0_START_LO  8'h08
`define IOWD_IDX_W0_START_HI  8'h09
`define IOWD_IDX_W0_END_LO    8'h0A
`define IOWD_IDX_W0_END_HI    8'h0B
`define IOWD_IDX_W1_START_LO  8'h0C
`define IOWD_IDX_W1_START_HI  8'h0D
`define IOWD_IDX_W1_END_LO    8'h0E
`define IOWD_IDX_W1_END_HI    8'h0F
`define IOWD_IDX_W0_OFS_LO    8'h36
`define IOWD_IDX_W0_OFS_HI    8'h37
`define IOWD_IDX_W1_OFS_LO    8'h38
`define IOWD_IDX_W1_OFS_HI    8'h39
`define IOWD_IDX_ACCESS       8'h40
`define IOWD_IDX_STATUS       8'h41
// Control register fields.
`define IOWD_CTL_W0_SIZE      0
`define IOWD_CTL_W0_AUTO      1
`define IOWD_CTL_W0_TSEL      3
`define IOWD_CTL_W1_SIZE      4
`define IOWD_CTL_W1_AUTO      5
`define IOWD_CTL_W1_TSEL      7
// Mapping enable fields.
`define IOWD_EN_W0            6
`define IOWD_EN_W1            7
// Access register fields: address in 15:0, strobe bit 16, card width indicator bit 17.
`define IOWD_ACC_ADDR_HI      15
`define IOWD_ACC_GO           16
`define IOWD_ACC_IND          17
// Reset values.
`define IOWD_RST_BYTE         8'h00
`define IOWD_RST_WORD         16'h0000
`define IOWD_RST_DATA         32'h0000_0000
`define IOWD_ZERO_BIT         1'b0
`define IOWD_ONE_BIT          1'b1
`endif

// [iowd_match.v]
// Window comparator: range check and card address forming for one I/O window.
// Assumes registered window settings and a 16-bit host I/O address.
`timescale 1ns/100ps
module iowd_match (
  input  wire        enable,
  input  wire [15:0] start_addr,
  input  wire [15:0] end_addr,
  input  wire [15:0] offset,
  input  wire [15:0] host_addr,
  output wire        hit,
  output wire [15:0] card_addr
);
  // A window claims the access only when enabled and start <= addr <= end.
  assign hit = enable && (host_addr >= start_addr) && (host_addr <= end_addr);
  // Offset sum wraps in 16 bits, as the card I/O space is 64K.
  assign card_addr = host_addr + offset;
endmodule

// [iowd_top.v]
// I/O window decoder for one socket: APB register file, two window comparators, card cycle launch.
// Assumes a synchronous host access strobe and a card width indicator sampled with it.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "iowd_defs.vh"
module iowd_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        host_io_valid,
  input  wire [15:0] host_io_addr,
  input  wire        card_io_width_indicator_n,
  output reg         io_claim,
  output reg         card_cycle,
  output reg  [15:0] card_io_addr,
  output reg         card_width16,
  output reg         card_timing_set1,
  output reg         card_window1
);
  // Register file; one copy per socket instance.
  reg [7:0]  map_enable_reg;
  reg [7:0]  io_window_control_reg;
  reg [7:0]  io_window0_start_low_reg;
  reg [7:0]  io_window0_start_high_reg;
  reg [7:0]  io_window0_end_low_reg;
  reg [7:0]  io_window0_end_high_reg;
  reg [7:0]  io_window1_start_low_reg;
  reg [7:0]  io_window1_start_high_reg;
  reg [7:0]  io_window1_end_low_reg;
  reg [7:0]  io_window1_end_high_reg;
  reg [7:0]  w0_offset_low_reg;
  reg [7:0]  w0_offset_high_reg;
  reg [7:0]  w1_offset_low_reg;
  reg [7:0]  w1_offset_high_reg;
  reg [31:0] rdata_next;
  reg        mapped_next;
  // Software access path launch request and last result status.
  reg        sw_go_reg;
  reg [15:0] sw_addr_reg;
  reg        sw_ind_reg;
  reg [7:0]  status_reg;

  // Byte address to register index; valid only for aligned word addresses.
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // Data path width choice shared by both windows.
  function pick_width16;
    input auto_size;
    input size_bit;
    input ind_n;
    begin
      pick_width16 = auto_size ? ~ind_n : size_bit;
    end
  endfunction

  wire        apb_setup = psel && !penable;
  wire        apb_write = psel && penable && pwrite && pready;
  wire [7:0]  idx       = reg_index(paddr);
  wire        aligned   = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h000000);

  // Host side inputs: either a bus access or a software-launched one.
  wire        acc_valid = host_io_valid | sw_go_reg;
  wire [15:0] acc_addr  = host_io_valid ? host_io_addr : sw_addr_reg;
  wire        acc_ind_n = host_io_valid ? card_io_width_indicator_n : ~sw_ind_reg;

  // Full 16-bit start and end per window built from their byte pairs.
  wire [15:0] w0_start = {io_window0_start_high_reg, io_window0_start_low_reg};
  wire [15:0] w1_start = {io_window1_start_high_reg, io_window1_start_low_reg};
  wire [15:0] w0_end   = {io_window0_end_high_reg, io_window0_end_low_reg};
  wire [15:0] w1_end   = {io_window1_end_high_reg, io_window1_end_low_reg};
  wire [15:0] w0_ofs   = {w0_offset_high_reg, w0_offset_low_reg};
  wire [15:0] w1_ofs   = {w1_offset_high_reg, w1_offset_low_reg};
  wire        w0_hit;
  wire        w1_hit;
  wire [15:0] w0_card;
  wire [15:0] w1_card;

  iowd_match u_win0 (
    .enable     (map_enable_reg[`IOWD_EN_W0]),
    .start_addr (w0_start),
    .end_addr   (w0_end),
    .offset     (w0_ofs),
    .host_addr  (acc_addr),
    .hit        (w0_hit),
    .card_addr  (w0_card)
  );

  iowd_match u_win1 (
    .enable     (map_enable_reg[`IOWD_EN_W1]),
    .start_addr (w1_start),
    .end_addr   (w1_end),
    .offset     (w1_ofs),
    .host_addr  (acc_addr),
    .hit        (w1_hit),
    .card_addr  (w1_card)
  );

  // Per-window width and timing; window 0 wins if software overlaps the two.
  wire w0_w16 = pick_width16(io_window_control_reg[`IOWD_CTL_W0_AUTO],
                             io_window_control_reg[`IOWD_CTL_W0_SIZE], acc_ind_n);
  wire w1_w16 = pick_width16(io_window_control_reg[`IOWD_CTL_W1_AUTO],
                             io_window_control_reg[`IOWD_CTL_W1_SIZE], acc_ind_n);
  wire w0_ts1 = io_window_control_reg[`IOWD_CTL_W0_TSEL];
  wire w1_ts1 = io_window_control_reg[`IOWD_CTL_W1_TSEL];
  wire any_hit = acc_valid && (w0_hit || w1_hit);

  // Card cycle launch; a miss leaves the access unclaimed and the card idle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_claim         <= `IOWD_ZERO_BIT;
      card_cycle       <= `IOWD_ZERO_BIT;
      card_io_addr     <= `IOWD_RST_WORD;
      card_width16     <= `IOWD_ZERO_BIT;
      card_timing_set1 <= `IOWD_ZERO_BIT;
      card_window1     <= `IOWD_ZERO_BIT;
      status_reg       <= `IOWD_RST_BYTE;
    end else begin
      io_claim   <= any_hit;
      card_cycle <= any_hit;
      if (any_hit) begin
        card_io_addr     <= w0_hit ? w0_card : w1_card;
        card_width16     <= w0_hit ? w0_w16 : w1_w16;
        card_timing_set1 <= w0_hit ? w0_ts1 : w1_ts1;
        card_window1     <= !w0_hit;
      end
      // Status records the last decode: bit0 claimed, bit1 window 1, bit2 width 16, bit3 timing set 1.
      if (acc_valid) begin
        status_reg <= {4'h0, (w0_hit ? w0_ts1 : w1_ts1), (w0_hit ? w0_w16 : w1_w16),
                       (!w0_hit && w1_hit), any_hit};
      end
    end
  end

  // Read decode; unmapped addresses read zero; unmapped or misaligned addresses raise pslverr.
  always @* begin
    rdata_next  = `IOWD_RST_DATA;
    mapped_next = aligned;
    case (idx)
      `IOWD_IDX_MAP_ENABLE:  rdata_next[7:0] = map_enable_reg;
      `IOWD_IDX_WIN_CTRL:    rdata_next[7:0] = io_window_control_reg;
      `IOWD_IDX_W0_START_LO: rdata_next[7:0] = io_window0_start_low_reg;
      `IOWD_IDX_W0_START_HI: rdata_next[7:0] = io_window0_start_high_reg;
      `IOWD_IDX_W0_END_LO:   rdata_next[7:0] = io_window0_end_low_reg;
      `IOWD_IDX_W0_END_HI:   rdata_next[7:0] = io_window0_end_high_reg;
      `IOWD_IDX_W1_START_LO: rdata_next[7:0] = io_window1_start_low_reg;
      `IOWD_IDX_W1_START_HI: rdata_next[7:0] = io_window1_start_high_reg;
      `IOWD_IDX_W1_END_LO:   rdata_next[7:0] = io_window1_end_low_reg;
      `IOWD_IDX_W1_END_HI:   rdata_next[7:0] = io_window1_end_high_reg;
      `IOWD_IDX_W0_OFS_LO:   rdata_next[7:0] = w0_offset_low_reg;
      `IOWD_IDX_W0_OFS_HI:   rdata_next[7:0] = w0_offset_high_reg;
      `IOWD_IDX_W1_OFS_LO:   rdata_next[7:0] = w1_offset_low_reg;
      `IOWD_IDX_W1_OFS_HI:   rdata_next[7:0] = w1_offset_high_reg;
      `IOWD_IDX_ACCESS:      rdata_next[17:0] = {sw_ind_reg, sw_go_reg, sw_addr_reg};
      `IOWD_IDX_STATUS:      rdata_next[7:0] = status_reg;
      default:               mapped_next = `IOWD_ZERO_BIT;
    endcase
  end

  // APB slave: ready one cycle after setup, so every transfer takes two cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= `IOWD_ZERO_BIT;
      pslverr <= `IOWD_ZERO_BIT;
      prdata  <= `IOWD_RST_DATA;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !mapped_next;
      if (apb_setup && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  // Register writes; all fields clear at reset; offset bit 0 stays zero and the launch bit self-clears.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_enable_reg            <= `IOWD_RST_BYTE;
      io_window_control_reg     <= `IOWD_RST_BYTE;
      io_window0_start_low_reg  <= `IOWD_RST_BYTE;
      io_window0_start_high_reg <= `IOWD_RST_BYTE;
      io_window0_end_low_reg    <= `IOWD_RST_BYTE;
      io_window0_end_high_reg   <= `IOWD_RST_BYTE;
      io_window1_start_low_reg  <= `IOWD_RST_BYTE;
      io_window1_start_high_reg <= `IOWD_RST_BYTE;
      io_window1_end_low_reg    <= `IOWD_RST_BYTE;
      io_window1_end_high_reg   <= `IOWD_RST_BYTE;
      w0_offset_low_reg         <= `IOWD_RST_BYTE;
      w0_offset_high_reg        <= `IOWD_RST_BYTE;
      w1_offset_low_reg         <= `IOWD_RST_BYTE;
      w1_offset_high_reg        <= `IOWD_RST_BYTE;
      sw_go_reg                 <= `IOWD_ZERO_BIT;
      sw_addr_reg               <= `IOWD_RST_WORD;
      sw_ind_reg                <= `IOWD_ZERO_BIT;
    end else begin
      // The launch strobe lasts one cycle; a host bus access in that cycle takes precedence.
      sw_go_reg <= `IOWD_ZERO_BIT;
      if (apb_write && aligned) begin
        case (idx)
          `IOWD_IDX_MAP_ENABLE:  map_enable_reg            <= pwdata[7:0];
          `IOWD_IDX_WIN_CTRL:    io_window_control_reg     <= pwdata[7:0];
          `IOWD_IDX_W0_START_LO: io_window0_start_low_reg  <= pwdata[7:0];
          `IOWD_IDX_W0_START_HI: io_window0_start_high_reg <= pwdata[7:0];
          `IOWD_IDX_W0_END_LO:   io_window0_end_low_reg    <= pwdata[7:0];
          `IOWD_IDX_W0_END_HI:   io_window0_end_high_reg   <= pwdata[7:0];
          `IOWD_IDX_W1_START_LO: io_window1_start_low_reg  <= pwdata[7:0];
          `IOWD_IDX_W1_START_HI: io_window1_start_high_reg <= pwdata[7:0];
          `IOWD_IDX_W1_END_LO:   io_window1_end_low_reg    <= pwdata[7:0];
          `IOWD_IDX_W1_END_HI:   io_window1_end_high_reg   <= pwdata[7:0];
          // Offset bit 0 must stay zero so card addresses keep host byte parity.
          `IOWD_IDX_W0_OFS_LO:   w0_offset_low_reg         <= {pwdata[7:1], `IOWD_ZERO_BIT};
          `IOWD_IDX_W0_OFS_HI:   w0_offset_high_reg        <= pwdata[7:0];
          `IOWD_IDX_W1_OFS_LO:   w1_offset_low_reg         <= {pwdata[7:1], `IOWD_ZERO_BIT};
          `IOWD_IDX_W1_OFS_HI:   w1_offset_high_reg        <= pwdata[7:0];
          `IOWD_IDX_ACCESS: begin
            sw_addr_reg <= pwdata[`IOWD_ACC_ADDR_HI:0];
            sw_go_reg   <= pwdata[`IOWD_ACC_GO];
            sw_ind_reg  <= pwdata[`IOWD_ACC_IND];
          end
          default: sw_go_reg <= `IOWD_ZERO_BIT;
        endcase
      end
    end
  end
endmodule

// [iowd_top_tb.sv]
// Testbench for the I/O window decoder: register file, window hits, misses and sizing.
// Assumes the card model answers the width indicator during each host access.
`timescale 1ns/100ps
`include "iowd_defs.vh"
module iowd_top_tb;
  reg         pclk, presetn, psel, penable, pwrite, host_io_valid, card_wide, err;
  reg  [31:0] paddr, pwdata, rd, wv;
  reg  [15:0] host_io_addr, s0, e0, s1, e1, o0, o1, last_ca;
  reg  [7:0]  ctl, map, j;
  wire [31:0] prdata;
  wire [15:0] card_io_addr;
  wire        pready, pslverr, ind_n, io_claim, card_cycle, card_width16, card_timing_set1, card_window1;
  integer     error_cnt, check_count, i, k;
  iowd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_io_valid(host_io_valid), .host_io_addr(host_io_addr), .card_io_width_indicator_n(ind_n),
    .io_claim(io_claim), .card_cycle(card_cycle), .card_io_addr(card_io_addr),
    .card_width16(card_width16), .card_timing_set1(card_timing_set1), .card_window1(card_window1));
  iowd_card_model i_card (.pclk(pclk), .host_io_valid(host_io_valid), .card_wide(card_wide),
    .card_io_width_indicator_n(ind_n));
  task chk(input [31:0] exp, input [31:0] got, input string what);
    begin
      check_count++;
      if (got !== exp) begin
        $display("unexpected %0s: expected %h, seen %h", what, exp, got);
        error_cnt++;
      end
    end
  endtask
  // One APB transfer; holds the request until pready is seen at a rising edge.
  task apb(input wr, input [7:0] idx, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Sample pready at each rising edge of the access phase, before the design updates it.
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (pready !== 1'b1) begin
        $display("unexpected pready: expected 1, seen %b", pready);
        error_cnt++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task prog;
    reg [63:0] v;
    begin
      v = {e1, s1, e0, s0};
      for (i = 0; i < 8; i++) apb(1'b1, `IOWD_IDX_W0_START_LO + i, v[8*i+:8]);
      v = {32'h0, o1, o0};
      for (i = 0; i < 4; i++) apb(1'b1, `IOWD_IDX_W0_OFS_LO + i, v[8*i+:8]);
      apb(1'b1, `IOWD_IDX_WIN_CTRL, ctl);
      apb(1'b1, `IOWD_IDX_MAP_ENABLE, map);
    end
  endtask
  // One host access; expectations come from the window ranges held in the bench.
  task acc(input [15:0] a, input wide);
    reg h0, h1;
    begin
      @(posedge pclk);
      host_io_valid <= 1'b1;
      host_io_addr <= a;
      card_wide <= wide;
      @(posedge pclk);
      host_io_valid <= 1'b0;
      card_wide <= 1'($urandom);
      h0 = map[6] && a >= s0 && a <= e0;
      h1 = map[7] && a >= s1 && a <= e1;
      if (h0 | h1) last_ca = h0 ? a + o0 : a + o1;
      #1;
      chk(h0 | h1, io_claim, "claim");
      chk(h0 | h1, card_cycle, "card_cycle");
      chk(last_ca, card_io_addr, "card_addr");
      if (h0 | h1) begin
        chk(h0 ? (ctl[1] ? wide : ctl[0]) : (ctl[5] ? wide : ctl[4]), card_width16, "width");
        chk(h0 ? ctl[3] : ctl[7], card_timing_set1, "timing");
        chk(!h0, card_window1, "window");
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Watchdog: the tests need well under a tenth of this span.
  initial begin
    #200000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    {psel, penable, pwrite, host_io_valid, card_wide, presetn} = 6'h00;
    {paddr, pwdata, host_io_addr, last_ca} = 96'h0;
    {s0, e0, s1, e1, o0, o1, ctl, map} = 112'h0;
    error_cnt = 0;
    check_count = 0;
    rd = $urandom(32'h1BE1);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset value, read back and upper-bit masking of every window register.
    for (k = 0; k < 14; k++) begin
      j = k < 10 ? 8'h06 + k : 8'h2C + k;
      apb(1'b0, j, 32'h0);
      chk(32'h0, rd, "reset value");
      wv = $urandom;
      apb(1'b1, j, wv);
      apb(1'b0, j, 32'h0);
      chk(wv[7:0] & ((j == 8'h36 || j == 8'h38) ? 8'hFE : 8'hFF), rd, "read back");
    end
    apb(1'b1, 8'h3F, 32'hFF);
    chk(1'b1, err, "unmapped error");
    // Random windows, modes and enables with boundary addresses on both sides.
    for (k = 0; k < 160; k++) begin
      if (k % 4 == 0) begin
        {s0, s1, o0, o1, ctl, map} = {$urandom, $urandom, $urandom};
        {o0[0], o1[0]} = 2'b00;
        // Windows live in the upper half, so they never cover the index and data ports.
        {s0[15], s1[15]} = 2'b11;
        // Every second setup behaves as an ATA disk card with window 1 auto-sized.
        if (k % 8 == 0) ctl[5] = 1'b1;
        e0 = s0 + 16'($urandom_range(40, 0));
        e1 = s1 + 16'($urandom_range(40, 0));
        prog;
      end
      acc(k[0] ? e0 + k[1] : s0 - k[1], 1'($urandom));
      acc(k[0] ? e1 + k[1] : s1 - k[1], 1'($urandom));
      acc(16'($urandom), 1'($urandom));
    end
    // Software-launched decode through the access register, then status and self-clear.
    {s0, e0, map, ctl} = {16'h8100, 16'h81FF, 8'h40, 8'h02};
    prog;
    apb(1'b1, `IOWD_IDX_ACCESS, 32'h0003_8120);
    @(posedge pclk);
    #1;
    chk(1'b1, io_claim, "go claim");
    chk(16'h8120 + o0, card_io_addr, "go card_addr");
    chk(1'b1, card_width16, "go width");
    apb(1'b0, `IOWD_IDX_STATUS, 32'h0);
    chk(32'h05, rd, "status");
    apb(1'b0, `IOWD_IDX_ACCESS, 32'h0);
    chk(32'h0002_8120, rd, "access self-clear");
    // A second reset clears the control register and the card address.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(16'h0, card_io_addr, "card_addr after reset");
    apb(1'b0, `IOWD_IDX_WIN_CTRL, 32'h0);
    chk(32'h0, rd, "control after reset");
    wrap_up;
  end
endmodule
